// File: hdl/hbm_consts.vh
/*
  Constants for the mode-one host bus port: control bit positions, wait-state
  counts and arbitration delays.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef HBM_CONSTS_VH
`define HBM_CONSTS_VH
`define HBM_CTL_FAST_ARB_BIT   1
`define HBM_CTL_ACK_EN_BIT     5
`define HBM_SNOOP_MODE_BIT     0
`define HBM_SLV_WAIT_CYCLES    2'h2
`define HBM_FETCH_TO_REQ       2'h1
`define HBM_GACK_TO_FETCH      2'h1
`define HBM_BURST_BEATS        2'h3
`endif

// File: hdl/hbm_sync2.v
/*
  Two flip-flop synchroniser for a vector of pin inputs.
  Assumes a single clock, synchronous active-high reset and a clock enable.
*/
module hbm_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk,   // Bus clock.
  input  wire         rst,   // Synchronous reset.
  input  wire         ce,    // Clock enable.
  input  wire [W-1:0] d,     // Asynchronous input.
  output reg  [W-1:0] q      // Synchronised output.
);
  reg [W-1:0] meta_r;

  always @(posedge clk) begin
    if (rst) begin
      meta_r <= INIT;
      q      <= INIT;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: hdl/hbm_negcap.v
/*
  Falling-edge capture register for data and the error and halt lines.
  Assumes the captured values are consumed on the following rising edge.
*/
module hbm_negcap #(
  parameter W = 32
) (
  input  wire         clk,   // Bus clock; captures on its falling edge.
  input  wire         rst,   // Synchronous reset.
  input  wire         ce,    // Clock enable.
  input  wire [W-1:0] d,     // Value from the bus.
  output reg  [W-1:0] q      // Value held since the last falling edge.
);
  always @(negedge clk) begin
    if (rst)
      q <= {W{1'b0}};
    else if (ce)
      q <= d;
  end
endmodule

// File: hdl/hbm_host_port.v
/*
  Mode-one host bus port: register slave, bus arbitration and master reads.
  Assumes an internal register file answers slave reads combinationally, and a
  master engine requests reads with a held request until done or error.
  Active-low bus lines carry the _n suffix; output enables are active low.
*/
`include "hbm_consts.vh"
module hbm_host_port (
  input  wire        clk,            // Bus clock, 40 MHz.
  input  wire        rst,            // Synchronous reset, active high.
  input  wire        ce,             // Clock enable; freezes all state when low.
  input  wire [7:0]  dma_control_register, // Control bits: ack enable, fast arbitration.
  input  wire [7:0]  chip_test_register,   // Test bits: snoop mode.
  input  wire        chip_select_n,  // Chip select pin.
  input  wire        address_qualifier_strobe_n_i, // Strobe pin, input side.
  output reg         address_qualifier_strobe_n_o, // Strobe drive value.
  output reg         address_qualifier_strobe_oe_n, // Strobe enable, low drives.
  input  wire        read_write_i,   // Direction pin from host, 1 is read.
  output reg         read_write_o,   // Direction drive value.
  input  wire [6:0]  address_i,      // Register address from host.
  output reg  [31:0] address_o,      // Master address.
  output reg         address_oe_n,   // Address and control enable, low drives.
  input  wire [1:0]  transfer_size_lines_i, // Size from host.
  output reg  [1:0]  transfer_size_lines_o, // Master size.
  input  wire [31:0] data_i,         // Data pins, input side.
  output reg  [31:0] data_o,         // Data drive value.
  output reg         data_oe_n,      // Data enable, low drives.
  output reg         data_phase_strobe_n,  // Data strobe drive value.
  output reg  [1:0]  snoop_control_lines,  // Snoop control outputs.
  output reg  [2:0]  function_code_lines,  // Function code outputs.
  output reg         general_purpose_output, // General purpose output.
  input  wire        burst_acknowledge_n_i, // Burst acknowledge from responder.
  output reg         burst_acknowledge_n_o, // Burst acknowledge drive value.
  output reg         burst_acknowledge_oe_n, // Burst acknowledge enable.
  output reg         burst_request_n,      // Burst request drive value.
  output reg         slave_acknowledge_n,  // Slave acknowledge output.
  input  wire        bus_error_line_n_i,   // Bus error pin, input side.
  output reg         bus_error_line_n_o,   // Bus error drive value.
  output reg         bus_error_line_oe_n,  // Bus error enable.
  input  wire        halt_n,               // Halt pin.
  input  wire        synchronous_termination_n_i, // Termination pin, input.
  output reg         synchronous_termination_n_o, // Termination drive value.
  output reg         synchronous_termination_oe_n, // Termination enable.
  output reg         bus_request_line_n,   // Bus request drive value.
  output reg         bus_request_oe_n,     // Bus request enable.
  input  wire        bus_grant_line_n,     // Bus grant pin.
  input  wire        grant_acknowledge_n_i, // Grant acknowledge pin, input.
  output reg         grant_acknowledge_n_o, // Grant acknowledge drive value.
  output reg         grant_acknowledge_oe_n, // Grant acknowledge enable.
  output reg         master_n,             // Master indicator.
  output reg         fetch_n,              // Opcode fetch indicator.
  input  wire        snoop_line_zero,      // Snoop line from system.
  output reg         slv_access,           // Slave access recognised, one-cycle pulse.
  output reg  [6:0]  slv_addr,             // Latched slave address.
  output reg         slv_write,            // Slave access is a write.
  output reg  [1:0]  slv_size,             // Latched slave size.
  input  wire [31:0] slv_rdata,            // Read data from register file.
  input  wire        slv_error,            // Register file flags an error.
  output reg  [31:0] slv_wdata,            // Write data sampled from the bus.
  output reg         slv_wstrobe,          // Write data valid, one-cycle pulse.
  input  wire        mst_req,              // Master read request, level.
  input  wire        mst_fetch,            // Request is an opcode fetch.
  input  wire [31:0] mst_addr,             // Master start address.
  input  wire [1:0]  mst_size,             // Master transfer size.
  input  wire [2:0]  mst_words,            // Beats wanted, one to four.
  input  wire [2:0]  mst_fc,               // Function code for the cycle.
  input  wire [1:0]  mst_sc,               // Snoop control for the cycle.
  input  wire        mst_gpo,              // General purpose value.
  output reg  [31:0] mst_rdata,            // Read beat data.
  output reg         mst_rvalid,           // Read beat valid, one-cycle pulse.
  output reg         mst_done,             // Transfer finished, one-cycle pulse.
  output reg         mst_fail              // Fatal bus error, one-cycle pulse.
);
  localparam S_IDLE = 4'h0, S_SWAIT = 4'h1, S_SANS = 4'h2, S_SHOLD = 4'h3;
  localparam S_FETCH = 4'h4, S_REQ = 4'h5, S_GRANT = 4'h6, S_ATTR = 4'h7;
  localparam S_ADDR = 4'h8, S_STRB = 4'h9, S_WAIT = 4'ha, S_REL = 4'hb;
  localparam S_FREL = 4'hc;

  // Pin inputs through two flip-flops.
  wire [6:0] sy;
  hbm_sync2 #(.W(7), .INIT(7'h7f)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({chip_select_n, address_qualifier_strobe_n_i, burst_acknowledge_n_i,
            synchronous_termination_n_i, bus_grant_line_n, grant_acknowledge_n_i,
            ~snoop_line_zero}),
    .q   (sy)
  );
  wire cs_s = ~sy[6];
  wire as_s = ~sy[5];
  wire burst_acknowledge_s = ~sy[4];
  wire synchronous_termination_s = ~sy[3];
  wire bg_s = ~sy[2];
  wire gack_s = ~sy[1];
  wire sc0_s = ~sy[0];

  // Falling-edge capture of data, error and halt.
  wire [33:0] neg_q;
  hbm_negcap #(.W(34)) u_neg (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({~bus_error_line_n_i, ~halt_n, data_i}),
    .q   (neg_q)
  );
  wire bus_error_line_f = neg_q[33];
  wire halt_f = neg_q[32];

  reg [3:0] st_r;
  reg [1:0] cnt_r;
  reg [2:0] left_r;
  reg       retry_r;
  reg       sc0_d_r;
  wire ack_en  = dma_control_register[`HBM_CTL_ACK_EN_BIT];
  wire fast    = dma_control_register[`HBM_CTL_FAST_ARB_BIT];
  wire snoop   = chip_test_register[`HBM_SNOOP_MODE_BIT];
  wire sc0_rise = sc0_s & ~sc0_d_r;

  always @(posedge clk) begin
    if (rst) begin
      st_r <= S_IDLE;
      cnt_r <= 2'h0;
      left_r <= 3'h0;
      retry_r <= 1'b0;
      sc0_d_r <= 1'b0;
      address_qualifier_strobe_n_o <= 1'b1;
      address_qualifier_strobe_oe_n <= 1'b1;
      read_write_o <= 1'b1;
      address_o <= 32'h0;
      address_oe_n <= 1'b1;
      transfer_size_lines_o <= 2'h0;
      data_o <= 32'h0;
      data_oe_n <= 1'b1;
      data_phase_strobe_n <= 1'b1;
      snoop_control_lines <= 2'h0;
      function_code_lines <= 3'h0;
      general_purpose_output <= 1'b0;
      burst_acknowledge_n_o <= 1'b1;
      burst_acknowledge_oe_n <= 1'b1;
      burst_request_n <= 1'b1;
      slave_acknowledge_n <= 1'b1;
      bus_error_line_n_o <= 1'b1;
      bus_error_line_oe_n <= 1'b1;
      synchronous_termination_n_o <= 1'b1;
      synchronous_termination_oe_n <= 1'b1;
      bus_request_line_n <= 1'b1;
      bus_request_oe_n <= 1'b1;
      grant_acknowledge_n_o <= 1'b1;
      grant_acknowledge_oe_n <= 1'b1;
      master_n <= 1'b1;
      fetch_n <= 1'b1;
      slv_access <= 1'b0;
      slv_addr <= 7'h0;
      slv_write <= 1'b0;
      slv_size <= 2'h0;
      slv_wdata <= 32'h0;
      slv_wstrobe <= 1'b0;
      mst_rdata <= 32'h0;
      mst_rvalid <= 1'b0;
      mst_done <= 1'b0;
      mst_fail <= 1'b0;
    end else if (ce) begin
      slv_access <= 1'b0;
      slv_wstrobe <= 1'b0;
      mst_rvalid <= 1'b0;
      mst_done <= 1'b0;
      mst_fail <= 1'b0;
      sc0_d_r <= sc0_s;
      case (st_r)
        S_IDLE: begin
          // Chip select only counts while the strobe is seen active.
          if (as_s && cs_s) begin
            slv_access <= 1'b1;
            slv_addr <= address_i;
            slv_write <= ~read_write_i;
            slv_size <= transfer_size_lines_i;
            burst_acknowledge_n_o <= 1'b1;
            burst_acknowledge_oe_n <= 1'b0;
            cnt_r <= `HBM_SLV_WAIT_CYCLES;
            st_r <= S_SWAIT;
          end else if (mst_req && !snoop) begin
            fetch_n <= ~mst_fetch;
            cnt_r <= `HBM_FETCH_TO_REQ;
            st_r <= S_FETCH;
          end else if (mst_req && snoop && sc0_rise) begin
            fetch_n <= ~mst_fetch;
            cnt_r <= `HBM_FETCH_TO_REQ;
            st_r <= S_FETCH;
          end
        end
        S_SWAIT: begin
          if (cnt_r == 2'h1) begin
            if (slv_write) begin
              slv_wdata <= neg_q[31:0];
              slv_wstrobe <= 1'b1;
            end else begin
              data_o <= slv_rdata;
              data_oe_n <= 1'b0;
            end
            st_r <= S_SANS;
          end
          cnt_r <= cnt_r - 2'h1;
        end
        S_SANS: begin
          slave_acknowledge_n <= slv_error;
          bus_error_line_oe_n <= ~slv_error;
          bus_error_line_n_o <= ~slv_error;
          synchronous_termination_oe_n <= ~ack_en;
          synchronous_termination_n_o <= ~(ack_en & ~slv_error);
          st_r <= S_SHOLD;
        end
        S_SHOLD: begin
          if (!as_s) begin
            slave_acknowledge_n <= 1'b1;
            bus_error_line_n_o <= 1'b1;
            bus_error_line_oe_n <= 1'b1;
            synchronous_termination_n_o <= 1'b1;
            synchronous_termination_oe_n <= 1'b1;
            burst_acknowledge_oe_n <= 1'b1;
            data_oe_n <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_FETCH: begin
          if (cnt_r == 2'h1) begin
            bus_request_line_n <= 1'b0;
            bus_request_oe_n <= 1'b0;
            st_r <= S_REQ;
          end
          cnt_r <= cnt_r - 2'h1;
        end
        S_REQ: begin
          if (bg_s && !gack_s) begin
            if (fast) begin
              grant_acknowledge_n_o <= 1'b0;
              grant_acknowledge_oe_n <= 1'b0;
              master_n <= 1'b0;
              bus_request_line_n <= 1'b1;
              bus_request_oe_n <= 1'b1;
              st_r <= S_ATTR;
            end else
              st_r <= S_GRANT;
          end
        end
        S_GRANT: begin
          grant_acknowledge_n_o <= 1'b0;
          grant_acknowledge_oe_n <= 1'b0;
          master_n <= 1'b0;
          bus_request_line_n <= 1'b1;
          bus_request_oe_n <= 1'b1;
          st_r <= S_ATTR;
        end
        S_ATTR: begin
          read_write_o <= 1'b1;
          snoop_control_lines <= mst_sc;
          function_code_lines <= mst_fc;
          general_purpose_output <= mst_gpo;
          address_oe_n <= 1'b0;
          left_r <= mst_words;
          address_o <= mst_addr;
          st_r <= S_ADDR;
        end
        S_ADDR: begin
          transfer_size_lines_o <= mst_size;
          st_r <= S_STRB;
        end
        S_STRB: begin
          address_qualifier_strobe_n_o <= 1'b0;
          address_qualifier_strobe_oe_n <= 1'b0;
          data_phase_strobe_n <= 1'b0;
          burst_request_n <= ~(left_r > 3'h1);
          st_r <= S_WAIT;
        end
        S_WAIT: begin
          if (bus_error_line_f && halt_f) begin
            retry_r <= 1'b1;
            address_qualifier_strobe_n_o <= 1'b1;
            data_phase_strobe_n <= 1'b1;
            burst_request_n <= 1'b1;
            st_r <= S_ADDR;
          end else if (bus_error_line_f) begin
            mst_fail <= 1'b1;
            retry_r <= 1'b0;
            st_r <= S_REL;
          end else if (synchronous_termination_s) begin
            mst_rdata <= neg_q[31:0];
            mst_rvalid <= 1'b1;
            left_r <= left_r - 3'h1;
            if (left_r == 3'h1) begin
              mst_done <= 1'b1;
              retry_r <= 1'b0;
              st_r <= S_REL;
            end else if (burst_acknowledge_s) begin
              address_o <= address_o + 32'h4;
            end else begin
              address_o <= address_o + 32'h4;
              address_qualifier_strobe_n_o <= 1'b1;
              data_phase_strobe_n <= 1'b1;
              burst_request_n <= 1'b1;
              st_r <= S_ADDR;
            end
          end
        end
        S_REL: begin
          master_n <= 1'b1;
          grant_acknowledge_n_o <= 1'b1;
          grant_acknowledge_oe_n <= 1'b1;
          address_qualifier_strobe_n_o <= 1'b1;
          address_qualifier_strobe_oe_n <= 1'b1;
          data_phase_strobe_n <= 1'b1;
          burst_request_n <= 1'b1;
          address_oe_n <= 1'b1;
          cnt_r <= `HBM_GACK_TO_FETCH;
          st_r <= S_FREL;
        end
        S_FREL: begin
          // Fetch stays asserted through any retry until success or fatal error.
          if (cnt_r == 2'h1 && !retry_r) begin
            fetch_n <= 1'b1;
            st_r <= S_IDLE;
          end
          cnt_r <= cnt_r - 2'h1;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

// File: verif/hbm_host_port_assertions.sv
/*
  Concurrent checks on the pins of the mode-one host bus port.
  Assumes one bus clock, the synchronous reset rst and binding to hbm_host_port.
*/
module hbm_host_port_assertions (
  input logic clk,                          // Bus clock.
  input logic rst,                          // Synchronous reset.
  input logic chip_select_n,                // Chip select pin.
  input logic address_qualifier_strobe_n_i, // Strobe level.
  input logic read_write_i,                 // Host direction.
  input logic data_oe_n,                    // Data enable.
  input logic slave_acknowledge_n,          // Slave acknowledge.
  input logic bus_error_line_n_o,           // Bus error drive value.
  input logic burst_acknowledge_n_o,        // Burst acknowledge value.
  input logic burst_acknowledge_oe_n,       // Burst acknowledge enable.
  input logic slv_access,                   // Access recognised.
  input logic fetch_n,                      // Fetch indicator.
  input logic bus_request_line_n,           // Bus request.
  input logic bus_grant_line_n,             // Bus grant.
  input logic grant_acknowledge_n_o,        // Grant acknowledge.
  input logic master_n,                     // Master indicator.
  input logic mst_done,                     // Transfer finished.
  input logic address_oe_n                  // Address enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_read_wait;
    data_oe_n [*2] ##1 !data_oe_n;
  endsequence
  sequence s_one_answer;
    slave_acknowledge_n != bus_error_line_n_o;
  endsequence
  sequence s_take_bus;
    !master_n && $past(!bus_grant_line_n) ##[0:1] bus_request_line_n;
  endsequence
  slv_recog_a: assert property (slv_access |->
    $past(!chip_select_n, 2) && $past(!address_qualifier_strobe_n_i, 2))
    else $error("slave access without chip select and strobe");
  no_burst_ack_a: assert property (slv_access |-> ##1 (!burst_acknowledge_oe_n && burst_acknowledge_n_o))
    else $error("burst acknowledge not held high");
  read_wait_a: assert property (slv_access && read_write_i |-> s_read_wait)
    else $error("read data not driven after two waits");
  slave_end_a: assert property (slv_access |-> ##3 s_one_answer)
    else $error("slave access not ended by one answer");
  strobe_release_a: assert property ($rose(address_qualifier_strobe_n_i) |->
    ##[1:4] (slave_acknowledge_n && data_oe_n))
    else $error("answer not released after strobe");
  no_cs_quiet_a: assert property (chip_select_n [*5] |-> slave_acknowledge_n && data_oe_n)
    else $error("answer without chip select");
  fetch_req_a: assert property ($fell(fetch_n) |-> ##[1:2] !bus_request_line_n)
    else $error("bus request late after fetch");
  grant_take_a: assert property ($fell(grant_acknowledge_n_o) |-> s_take_bus)
    else $error("bus taken without grant");
  done_release_a: assert property (mst_done |=> master_n && address_oe_n)
    else $error("bus not released after last beat");
  fetch_release_a: assert property ($rose(grant_acknowledge_n_o) && !fetch_n |-> ##[1:2] fetch_n)
    else $error("fetch indicator not released");
endmodule

bind hbm_host_port hbm_host_port_assertions i_hbm_host_port_assertions (.*);

// File: verif/hbm_host_model.sv
/*
  Bus arbiter and memory responder on the far side of the host bus port.
  Assumes levels already resolved from all drivers; one beat slot every four clocks.
*/
module hbm_host_model (
  input  logic        clk,      // Bus clock.
  input  logic        rst,      // Synchronous reset.
  input  logic        req_n,    // Bus request level.
  input  logic        gack_n,   // Grant acknowledge level.
  input  logic        as_n,     // Address strobe level.
  input  logic        adr_oe_n, // Low while the device owns the address lines.
  input  logic        breq_n,   // Burst request level.
  input  logic        burst_en, // Answer burst requests.
  input  logic [1:0]  err_mode, // 1 retry once, 2 fatal error once.
  output logic        grant_n,  // Bus grant.
  output logic        synchronous_termination_n,  // Synchronous termination.
  output logic        back_n,   // Burst acknowledge.
  output logic        bus_error_line_n,   // Bus error.
  output logic        halt_n,   // Halt.
  output logic [31:0] data      // Read data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  gap;
  logic [1:0]  mode;
  logic [31:0] beat;
  always @(posedge clk) begin
    if (rst) begin
      {grant_n, synchronous_termination_n, back_n, bus_error_line_n, halt_n} <= 5'h1f;
      {gap, mode, beat, data} <= '0;
    end else begin
      synchronous_termination_n <= 1'b1;
      grant_n <= !((!req_n || !grant_n) && gack_n);
      back_n <= !(burst_en && !breq_n);
      if (!req_n && gack_n)
        mode <= err_mode;
      if (as_n || adr_oe_n) begin
        // Released data lines show a changing pattern, not the last beat.
        gap <= 2'h0;
        bus_error_line_n <= 1'b1;
        halt_n <= 1'b1;
        data <= ~data;
        if (adr_oe_n)
          beat <= '0;
      end else begin
        gap <= gap + 2'h1;
        if (gap == 2'h2) begin
          bus_error_line_n <= 1'b1;
          halt_n <= 1'b1;
        end
        if (gap == 2'h3 && mode != 2'h0) begin
          bus_error_line_n <= 1'b0;
          halt_n <= (mode != 2'h1);
          mode <= 2'h0;
        end else if (gap == 2'h3) begin
          synchronous_termination_n <= 1'b0;
          data <= 32'hd000_0000 + beat;
          beat <= beat + 32'h1;
        end
      end
    end
  end
endmodule

// File: verif/hbm_host_port_tb.sv
/*
  Self-checking bench for the mode-one host bus port: slave cycles, arbitration, master reads.
  Assumes hbm_host_model as arbiter and memory; the bench plays host and register file.
*/
module hbm_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ce = 1, chip_select_n = 1, read_write_i = 1, host_as_n = 1, slv_error = 0;
  logic mst_req = 0, mst_fetch = 1, mst_gpo = 1, snoop_line_zero = 0, burst_en = 1;
  logic [7:0] dma_control_register = 0, chip_test_register = 0;
  logic [6:0] address_i = 0;
  logic [1:0] transfer_size_lines_i = 0, mst_size = 0, mst_sc = 1, err_mode = 0;
  logic [2:0] mst_words = 1, mst_fc = 5;
  logic [31:0] host_data = 0, mst_addr = 0;
  wire address_qualifier_strobe_n_i, address_qualifier_strobe_n_o, address_qualifier_strobe_oe_n, read_write_o;
  wire address_oe_n, data_oe_n, data_phase_strobe_n, general_purpose_output, burst_acknowledge_n_i;
  wire burst_acknowledge_n_o, burst_acknowledge_oe_n, burst_request_n, slave_acknowledge_n, bus_error_line_n_i;
  wire bus_error_line_n_o, bus_error_line_oe_n, halt_n, synchronous_termination_n_i, synchronous_termination_n_o;
  wire synchronous_termination_oe_n, bus_request_line_n, bus_request_oe_n, bus_grant_line_n, grant_acknowledge_n_i;
  wire grant_acknowledge_n_o, grant_acknowledge_oe_n, master_n, fetch_n, slv_access, slv_write, slv_wstrobe;
  wire mst_rvalid, mst_done, mst_fail, m_synchronous_termination_n, m_back_n, m_bus_error_line_n;
  wire [1:0] transfer_size_lines_o, snoop_control_lines, slv_size;
  wire [2:0] function_code_lines;
  wire [6:0] slv_addr;
  wire [31:0] address_o, data_i, data_o, slv_rdata, slv_wdata, mst_rdata, m_data;
  int mismatches = 0, compares = 0, cyc = 0;
  always #12.5 clk = ~clk;
  assign address_qualifier_strobe_n_i = address_qualifier_strobe_oe_n ? host_as_n : address_qualifier_strobe_n_o;
  assign burst_acknowledge_n_i = burst_acknowledge_oe_n ? m_back_n : burst_acknowledge_n_o;
  assign bus_error_line_n_i = bus_error_line_oe_n ? m_bus_error_line_n : bus_error_line_n_o;
  assign synchronous_termination_n_i = synchronous_termination_oe_n ? m_synchronous_termination_n : synchronous_termination_n_o;
  assign grant_acknowledge_n_i = grant_acknowledge_oe_n | grant_acknowledge_n_o;
  assign data_i = !data_oe_n ? data_o : (!address_oe_n ? m_data : host_data);
  assign slv_rdata = 32'hc0de_0000 | slv_addr;
  hbm_host_port i_hbm_host_port (.*);
  hbm_host_model i_hbm_host_model (.clk(clk), .rst(rst), .req_n(bus_request_oe_n | bus_request_line_n),
    .gack_n(grant_acknowledge_n_i), .as_n(address_qualifier_strobe_n_i), .adr_oe_n(address_oe_n),
    .breq_n(burst_request_n), .burst_en(burst_en), .err_mode(err_mode), .grant_n(bus_grant_line_n),
    .synchronous_termination_n(m_synchronous_termination_n), .back_n(m_back_n), .bus_error_line_n(m_bus_error_line_n), .halt_n(halt_n), .data(m_data));
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hangs cut short: the whole run needs well under 5000 clocks.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic slave(input logic rd, input logic [6:0] a, input logic err, input logic [31:0] wd);
    logic [31:0] seen = 32'h0;
    int n = 0;
    @(posedge clk);
    read_write_i <= rd;
    address_i <= a;
    transfer_size_lines_i <= a[1:0];
    slv_error <= err;
    @(posedge clk);
    host_as_n <= 1'b0;
    @(posedge clk);
    chip_select_n <= 1'b0;
    host_data <= wd;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (slv_wstrobe === 1'b1)
        seen = slv_wdata;
    end while (slave_acknowledge_n !== 1'b0 && (bus_error_line_oe_n | bus_error_line_n_o) !== 1'b0 && n < 20);
    chk(slave_acknowledge_n, err);
    chk(bus_error_line_oe_n | bus_error_line_n_o, !err);
    chk({slv_addr, slv_write}, {a, !rd});
    if (rd && !err)
      chk({data_oe_n, data_o}, {1'b0, 32'hc0de_0000 | a});
    if (!rd)
      chk(seen, wd);
    chk({synchronous_termination_oe_n, synchronous_termination_n_o}, {1'b0, err});
    chk({burst_acknowledge_oe_n, burst_acknowledge_n_o, slv_size}, {2'b01, a[1:0]});
    @(posedge clk);
    host_as_n <= 1'b1;
    chip_select_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({data_oe_n, slave_acknowledge_n, bus_error_line_oe_n | bus_error_line_n_o}, 3'h7);
    chk({synchronous_termination_oe_n, burst_acknowledge_oe_n}, 2'h3);
  endtask
  task automatic mread(input logic fast, input logic [1:0] em, input logic snp, input logic [2:0] w, output int lat);
    int k = 0, n = 0, g = -1;
    logic pas = 1'b1;
    lat = -1;
    @(posedge clk);
    dma_control_register <= {6'h0, fast, 1'b0};
    chip_test_register <= {7'h0, snp};
    {err_mode, mst_words, mst_addr, mst_req} <= {em, w, 32'h0000_2000, 1'b1};
    if (snp) begin
      repeat (6) @(posedge clk);
      #1;
      chk(bus_request_line_n, 1'b1);
      @(posedge clk);
      snoop_line_zero <= 1'b1;
    end
    while (mst_done !== 1'b1 && mst_fail !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      if (snp && n == 5)
        chk(bus_request_line_n, 1'b0);
      if (bus_grant_line_n === 1'b0 && g < 0)
        g = n;
      if (grant_acknowledge_n_o === 1'b0 && lat < 0)
        lat = n - g;
      if (master_n === 1'b0)
        chk(fetch_n, 1'b0);
      if (address_qualifier_strobe_n_o === 1'b0 && pas) begin
        chk(address_o, 32'h0000_2000 + 4 * k);
        chk({function_code_lines, snoop_control_lines, general_purpose_output}, {mst_fc, mst_sc, mst_gpo});
        chk({read_write_o, transfer_size_lines_o, data_phase_strobe_n}, {1'b1, mst_size, 1'b0});
        chk({address_qualifier_strobe_oe_n, burst_request_n}, {1'b0, k + 1 >= w});
      end
      pas = address_qualifier_strobe_n_o;
      if (mst_rvalid === 1'b1) begin
        chk(mst_rdata, 32'hd000_0000 + k);
        k++;
      end
    end
    chk({mst_fail, 3'(k)}, {em == 2'h2, em == 2'h2 ? 3'h0 : w});
    @(posedge clk);
    {mst_req, snoop_line_zero, err_mode} <= 4'h0;
    repeat (6) @(posedge clk);
    #1;
    chk({master_n, fetch_n, address_oe_n}, 3'h7);
    chk({address_qualifier_strobe_oe_n, bus_request_oe_n, grant_acknowledge_oe_n}, 3'h7);
  endtask
  task automatic t_slave();
    @(posedge clk);
    dma_control_register <= 8'h20;
    slave(1'b1, 7'h7f, 1'b0, 32'h0);
    slave(1'b0, 7'h00, 1'b0, 32'ha5c3_1e0f);
    slave(1'b1, 7'h12, 1'b1, 32'h0);
    slave(1'b0, 7'h34, 1'b1, 32'h5a3c_e1f0);
    $display("test slave cycles done");
  endtask
  task automatic t_nocs();
    @(posedge clk);
    host_as_n <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      chk({slv_access, data_oe_n, slave_acknowledge_n}, 3'h3);
    end
    @(posedge clk);
    host_as_n <= 1'b1;
    $display("test strobe without chip select done");
  endtask
  task automatic t_master();
    int l0, l1, l;
    mread(1'b0, 2'h0, 1'b0, 3'h4, l0);
    @(posedge clk);
    burst_en <= 1'b0;
    mread(1'b1, 2'h0, 1'b0, 3'h2, l1);
    chk(l0 - l1, 1);
    @(posedge clk);
    burst_en <= 1'b1;
    mread(1'b0, 2'h1, 1'b0, 3'h3, l);
    mread(1'b0, 2'h2, 1'b0, 3'h1, l);
    mread(1'b0, 2'h0, 1'b1, 3'h1, l);
    $display("test master reads done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({fetch_n, master_n, bus_request_line_n, slave_acknowledge_n, data_oe_n, slv_access}, 6'h3e);
    $display("test reset done");
    t_slave();
    t_nocs();
    t_master();
    give_verdict();
  end
endmodule
